// >>> rtl/cfm_monitor.sv
// Purpose: Fault, error and warning supervision of a step-down converter.
// Assumes: Measurements, commands and ramp status come from logic on SYS_CLK.
// Notes: The power-good pin is open drain; its level is read back through a synchroniser.
// Function
// - Set temperature warning when controller temperature rises above 120 C.
// - Clear temperature warning only once temperature drops below 117 C.
// - Warnings never shut the converter down; they only drive status and the power-good pin.
// - Pull power-good low when output leaves the selectable window.
// - Window check only runs once output has reached steady state.
// - Delay power-good release after steady state by 0 to 150 ms.
// - Limits are percentages of setpoint, so they track margining changes.
// - Power-good warning pulls pin low and clears its status bit.
// - External pull-low of power-good counts as a power-good warning.
// - At turn-off, power-good drops at the command or at ramp-down start.
// - Any fault in the fault group switches the converter off.
// - Overcurrent detection is armed only above the pre-bias voltage.
// - Overcurrent asserts fault, clears its bit, switches both transistors off.
// - Undervoltage in steady state without overcurrent flags fault and turns off.
// - Undervoltage turn-off is a regular ramp-down, not a fast one.
// - Bits 7:5 of current-limit register select the load-regulation slope.
// - Bit 4 enables current-limit temperature compensation, enabled by default.
// - Bits 3:0 select current limit; codes above 0xB act as 0xB.
// - Without latching, restart every 130 ms until the fault condition clears.
`timescale 1ns/100ps
module cfm_monitor
  import cfm_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic SYS_CLK, // System clock, 10 MHz.
  input wire logic RSTN, // Asynchronous reset, active low.
  input wire cfm_meas_type MEAS, // Sampled temperature, voltages and current.
  input wire cfm_cfg_type CFG, // Protection configuration.
  input wire logic TURN_ON, // Turn-on command level.
  input wire logic RAMP_DONE, // Output has reached its steady-state level.
  input wire logic VOUT_FALLING, // Output has begun to ramp down.
  input wire logic OFF_DONE, // Regular ramp-down has finished.
  input wire logic REG_WR, // Register write strobe.
  input wire logic [7:0] REG_ADDR, // Register address.
  input wire logic [7:0] REG_WDATA, // Register write data.
  output logic [7:0] REG_RDATA, // Register read data.
  input wire logic PG_IN, // Level seen on the power-good pin.
  output logic PG_OUT, // Power-good pin drive value, always low.
  output logic PG_OE, // Pulls the power-good pin low when high.
  output logic CONV_ENABLE, // Converter runs and ramps normally.
  output logic FAST_OFF, // Both switches off at once.
  output cfm_status_type STATUS, // Status flags.
  output logic [2:0] LOAD_REG_SELECT, // Load-regulation slope code.
  output logic LIMIT_TEMP_COMP_EN, // Current-limit temperature compensation.
  output logic [7:0] CURRENT_LIMIT_PCT // Active current limit in percent.
);

  // Scale a millivolt value by a percentage, wide enough for no overflow.
  function automatic logic [23:0] mul_pct(input logic [15:0] v, input logic [6:0] p);
    return 24'(v) * 24'(p);
  endfunction

  // Map a current-limit code to percent of rated current.
  function automatic logic [7:0] limit_pct(input logic [3:0] code);
    case (code)
      4'h0: return 8'h25;
      4'h1: return 8'h2f;
      4'h2: return 8'h38;
      4'h3: return 8'h41;
      4'h4: return 8'h4b;
      4'h5: return 8'h54;
      4'h6: return 8'h5d;
      4'h7: return 8'h67;
      4'h8: return 8'h70;
      4'h9: return 8'h79;
      4'ha: return 8'h83;
      default: return CL_MAX_PCT;
    endcase
  endfunction

  logic [7:0] cls_r;
  logic [7:0] cls_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] climit_r;
  logic [7:0] climit_nxt;
  logic pg_meta_r;
  logic pg_sync_r;
  logic [2:0] oe_hist_r;
  cfm_state_type state_r;
  cfm_state_type state_nxt;
  logic conv_en_r;
  logic conv_en_nxt;
  logic fast_off_r;
  logic fast_off_nxt;
  logic pend_r;
  logic pend_nxt;
  logic pend_latch_r;
  logic pend_latch_nxt;
  logic temp_warn_r;
  logic temp_warn_nxt;
  logic pg_good_r;
  logic pg_good_nxt;
  logic oc_flag_r;
  logic oc_flag_nxt;
  logic uv_flag_r;
  logic uv_flag_nxt;
  logic pg_oe_r;
  logic pg_out_r;
  logic pg_ok;
  logic ext_hold_r;
  logic ext_hold_nxt;
  logic tmr_start;
  logic [7:0] tmr_target;
  logic tmr_done;
  logic ext_low;
  logic in_window;
  logic oc_hit;
  logic uv_hit;
  logic [6:0] pg_hi_pct;
  logic [6:0] pg_lo_pct;
  logic [7:0] pg_delay;

  // Register writes and read data for the current-limit register.
  always_comb begin
    cls_nxt = cls_r;
    if (REG_WR && REG_ADDR == CLS_OFFSET) begin
      cls_nxt = REG_WDATA;
    end
    if (REG_ADDR == CLS_OFFSET) begin
      rdata_nxt = cls_r;
    end else begin
      rdata_nxt = 8'h00;
    end
    climit_nxt = limit_pct(cls_r[CL_MSB:CL_LSB]);
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cls_r <= CLS_RESET;
      rdata_r <= 8'h00;
      climit_r <= CL_MAX_PCT;
    end else begin
      cls_r <= cls_nxt;
      rdata_r <= rdata_nxt;
      climit_r <= climit_nxt;
    end
  end

  // Synchronise the pin level and remember recent own drive for masking.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pg_meta_r <= 1'b1;
      pg_sync_r <= 1'b1;
      oe_hist_r <= 3'h7;
    end else begin
      pg_meta_r <= PG_IN;
      pg_sync_r <= pg_meta_r;
      oe_hist_r <= {oe_hist_r[1:0], pg_oe_r};
    end
  end

  // A low pin that is not our own recent drive comes from an outside circuit.
  assign ext_low = !pg_sync_r && !pg_oe_r && (oe_hist_r == 3'h0);

  // Window and undervoltage comparisons against the live setpoint; overcurrent against the pre-bias level and current limit.
  assign pg_hi_pct = CFG.pg_high_sel ? PG_HIGH_110 : PG_HIGH_105;
  assign pg_lo_pct = CFG.pg_low_sel ? PG_LOW_95 : PG_LOW_90;
  assign pg_delay = (CFG.pg_delay_ms > PG_DELAY_MAX_MS) ? PG_DELAY_MAX_MS : CFG.pg_delay_ms;
  assign in_window = !(mul_pct(MEAS.vout_mv, PCT_FULL) > mul_pct(MEAS.vset_mv, pg_hi_pct))
    && !(mul_pct(MEAS.vout_mv, PCT_FULL) < mul_pct(MEAS.vset_mv, pg_lo_pct));
  assign oc_hit = (state_r == ST_RAMP_UP || state_r == ST_STEADY)
    && (MEAS.vout_mv > MEAS.vprebias_mv) && (MEAS.iout_pct >= climit_r);
  assign uv_hit = (state_r == ST_STEADY) && !oc_hit
    && (mul_pct(MEAS.vout_mv, PCT_FULL) < mul_pct(MEAS.vset_mv, CFG.uv_pct));

  // Sequencing, fault response and restart control.
  always_comb begin
    state_nxt = state_r;
    fast_off_nxt = fast_off_r;
    pend_nxt = pend_r;
    pend_latch_nxt = pend_latch_r;
    oc_flag_nxt = oc_flag_r;
    uv_flag_nxt = uv_flag_r;
    case (state_r)
      ST_OFF: begin
        fast_off_nxt = 1'b0;
        if (TURN_ON) begin
          state_nxt = ST_RAMP_UP;
          oc_flag_nxt = 1'b1;
          uv_flag_nxt = 1'b1;
        end
      end
      ST_RAMP_UP, ST_STEADY: begin
        if (oc_hit) begin
          state_nxt = CFG.latch_oc ? ST_LATCHED : ST_RETRY;
          fast_off_nxt = 1'b1;
          oc_flag_nxt = 1'b0;
        end else if (uv_hit) begin
          state_nxt = ST_RAMP_DOWN;
          pend_nxt = 1'b1;
          pend_latch_nxt = CFG.latch_uv;
          uv_flag_nxt = 1'b0;
        end else if (!TURN_ON) begin
          state_nxt = ST_RAMP_DOWN;
          pend_nxt = 1'b0;
        end else if (state_r == ST_RAMP_UP && RAMP_DONE) begin
          state_nxt = ST_STEADY;
        end
      end
      ST_RAMP_DOWN: begin
        if (OFF_DONE) begin
          pend_nxt = 1'b0;
          if (!pend_r) begin
            state_nxt = ST_OFF;
          end else if (pend_latch_r) begin
            state_nxt = ST_LATCHED;
          end else begin
            state_nxt = ST_RETRY;
          end
        end
      end
      ST_RETRY: begin
        if (tmr_done) begin
          fast_off_nxt = 1'b0;
          if (TURN_ON) begin
            state_nxt = ST_RAMP_UP;
            oc_flag_nxt = 1'b1;
            uv_flag_nxt = 1'b1;
          end else begin
            state_nxt = ST_OFF;
          end
        end
      end
      default: begin
        if (!TURN_ON) begin
          state_nxt = ST_OFF;
        end
      end
    endcase
    conv_en_nxt = (state_nxt == ST_RAMP_UP) || (state_nxt == ST_STEADY);
  end

  // The shared timer measures the power-good delay or the restart wait.
  assign tmr_start = (state_nxt != state_r)
    && (state_nxt == ST_STEADY || state_nxt == ST_RETRY);
  assign tmr_target = (state_nxt == ST_STEADY) ? pg_delay : RETRY_MS;

  cfm_ms_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .start(tmr_start),
    .target_ms(tmr_target),
    .done(tmr_done)
  );

  // Warning logic; none of it reaches the sequencing above.
  always_comb begin
    if (temp_warn_r) begin
      temp_warn_nxt = !(MEAS.temp_c < TEMP_WARN_CLR_C);
    end else begin
      temp_warn_nxt = MEAS.temp_c > TEMP_WARN_SET_C;
    end
    case (state_r)
      ST_STEADY: begin
        pg_ok = tmr_done && in_window && (TURN_ON || CFG.pg_off_mode);
      end
      ST_RAMP_DOWN: begin
        pg_ok = (pg_good_r || ext_hold_r) && CFG.pg_off_mode && !VOUT_FALLING;
      end
      default: begin
        pg_ok = 1'b0;
      end
    endcase
    // An outside pull-low is held as a warning until the released pin reads high again.
    ext_hold_nxt = pg_ok && (ext_low || (ext_hold_r && !pg_sync_r));
    pg_good_nxt = pg_ok && !ext_hold_nxt;
  end

  // Register sequencing state, flags and pin drive.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= ST_OFF;
      conv_en_r <= 1'b0;
      fast_off_r <= 1'b0;
      pend_r <= 1'b0;
      pend_latch_r <= 1'b0;
      oc_flag_r <= 1'b1;
      uv_flag_r <= 1'b1;
      temp_warn_r <= 1'b0;
      pg_good_r <= 1'b0;
      ext_hold_r <= 1'b0;
      pg_oe_r <= 1'b1;
      pg_out_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      conv_en_r <= conv_en_nxt;
      fast_off_r <= fast_off_nxt;
      pend_r <= pend_nxt;
      pend_latch_r <= pend_latch_nxt;
      oc_flag_r <= oc_flag_nxt;
      uv_flag_r <= uv_flag_nxt;
      temp_warn_r <= temp_warn_nxt;
      pg_good_r <= pg_good_nxt;
      ext_hold_r <= ext_hold_nxt;
      pg_oe_r <= !pg_ok;
      pg_out_r <= 1'b0;
    end
  end

  // Output assignments, each from a flip-flop.
  assign REG_RDATA = rdata_r;
  assign PG_OUT = pg_out_r;
  assign PG_OE = pg_oe_r;
  assign CONV_ENABLE = conv_en_r;
  assign FAST_OFF = fast_off_r;
  assign STATUS = {temp_warn_r, temp_warn_r, pg_good_r, oc_flag_r, uv_flag_r};
  assign LOAD_REG_SELECT = cls_r[LR_MSB:LR_LSB];
  assign LIMIT_TEMP_COMP_EN = cls_r[TCE_BIT];
  assign CURRENT_LIMIT_PCT = climit_r;

  chk_temp_set: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (MEAS.temp_c > TEMP_WARN_SET_C) |=> STATUS.temp_warning_flag)
    else $error("temperature warning not set above limit");
  chk_temp_hold: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    temp_warn_r && !(MEAS.temp_c < TEMP_WARN_CLR_C) |=> temp_warn_r)
    else $error("temperature warning cleared inside hysteresis band");
  chk_warn_no_off: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state_r == ST_STEADY && TURN_ON && !oc_hit && !uv_hit |=> conv_en_r && !fast_off_r)
    else $error("converter stopped without a fault");
  chk_pg_window: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state_r == ST_STEADY && !in_window |=> PG_OE && !STATUS.power_good_flag)
    else $error("power good released outside window");
  chk_pg_steady: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    !PG_OE |-> $past(state_r) == ST_STEADY || $past(state_r) == ST_RAMP_DOWN)
    else $error("power good released before steady state");
  chk_pg_delay: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(state_r == ST_STEADY) && CFG.pg_delay_ms != 8'h00 |-> PG_OE [*2])
    else $error("power good released without delay");
  chk_pg_extern: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    ext_low |=> !STATUS.power_good_flag)
    else $error("external pull low not taken as warning");
  chk_pg_turnoff: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state_r == ST_STEADY && !TURN_ON && !CFG.pg_off_mode |=> PG_OE)
    else $error("power good held after turn-off command");
  chk_oc_fast: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    oc_hit |=> FAST_OFF && !CONV_ENABLE && !STATUS.overcurrent_flag)
    else $error("overcurrent did not force fast turn-off");
  chk_uv_regular: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    uv_hit |=> state_r == ST_RAMP_DOWN && !FAST_OFF && !STATUS.undervoltage_flag)
    else $error("undervoltage did not start regular turn-off");
  chk_retry_wait: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(state_r == ST_RETRY) |-> (state_r == ST_RETRY) [*8])
    else $error("restart came before the wait");
  chk_limit_sat: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    cls_r[CL_MSB:CL_LSB] > CL_MAX_CODE |=> CURRENT_LIMIT_PCT == CL_MAX_PCT)
    else $error("current limit code not saturated");

endmodule

// >>> rtl/cfm_pkg.sv
// Purpose: Shared constants and carrier types for the converter fault monitor.
// Assumes: A 10 MHz system clock; measurements arrive already digitised on that clock.
// Notes: Percentages are plain integers of the output setpoint or of rated current.
package cfm_pkg;

  // The current-limit register and its fields.
  localparam logic [7:0] CLS_OFFSET = 8'h08;
  localparam logic [7:0] CLS_RESET = 8'h1b;
  localparam int LR_MSB = 7;
  localparam int LR_LSB = 5;
  localparam int TCE_BIT = 4;
  localparam int CL_MSB = 3;
  localparam int CL_LSB = 0;
  localparam logic [3:0] CL_MAX_CODE = 4'hb;
  localparam logic [7:0] CL_MAX_PCT = 8'h8c;

  // Overtemperature warning set and clear levels in degrees Celsius.
  localparam logic signed [7:0] TEMP_WARN_SET_C = 8'sh78;
  localparam logic signed [7:0] TEMP_WARN_CLR_C = 8'sh75;

  // Power-good window limits in percent of the setpoint.
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] PG_HIGH_105 = 7'h69;
  localparam logic [6:0] PG_HIGH_110 = 7'h6e;
  localparam logic [6:0] PG_LOW_90 = 7'h5a;
  localparam logic [6:0] PG_LOW_95 = 7'h5f;

  // Timing in milliseconds and the cycles that make one millisecond.
  localparam logic [7:0] PG_DELAY_MAX_MS = 8'h96;
  localparam logic [7:0] RETRY_MS = 8'h82;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

  // Sequencing states of the converter.
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RAMP_UP = 3'b001,
    ST_STEADY = 3'b010,
    ST_RAMP_DOWN = 3'b011,
    ST_RETRY = 3'b100,
    ST_LATCHED = 3'b101
  } cfm_state_type;

  // Measurements sampled by the converter front end.
  typedef struct packed {
    logic signed [7:0] temp_c;
    logic [15:0] vout_mv;
    logic [15:0] vset_mv;
    logic [15:0] vprebias_mv;
    logic [7:0] iout_pct;
  } cfm_meas_type;

  // Protection configuration held outside this block.
  typedef struct packed {
    logic pg_high_sel;
    logic pg_low_sel;
    logic [6:0] uv_pct;
    logic [7:0] pg_delay_ms;
    logic pg_off_mode;
    logic latch_oc;
    logic latch_uv;
  } cfm_cfg_type;

  // Status flags; the power-good and fault bits read 0 while the event stands.
  typedef struct packed {
    logic temp_warning_flag;
    logic temp_warning_alias_flag;
    logic power_good_flag;
    logic overcurrent_flag;
    logic undervoltage_flag;
  } cfm_status_type;

endpackage

// >>> rtl/cfm_ms_timer.sv
// Purpose: Millisecond interval timer shared by power-good delay and restart wait.
// Assumes: Start is a one-cycle pulse from logic on the same clock.
// Notes: Done rises once the target count of milliseconds has passed and then holds.
`timescale 1ns/100ps
module cfm_ms_timer
  import cfm_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic start, // Restarts the interval.
  input wire logic [7:0] target_ms, // Interval length in milliseconds.
  output logic done // Interval has elapsed.
);

  logic [23:0] pre_r;
  logic [23:0] pre_nxt;
  logic [7:0] ms_r;
  logic [7:0] ms_nxt;
  logic run_r;
  logic run_nxt;
  logic done_r;
  logic done_nxt;

  // Prescale to milliseconds and count them up to the target.
  always_comb begin
    pre_nxt = pre_r;
    ms_nxt = ms_r;
    run_nxt = run_r;
    done_nxt = done_r;
    if (start) begin
      pre_nxt = 24'h000000;
      ms_nxt = 8'h00;
      run_nxt = 1'b1;
      done_nxt = 1'b0;
    end else if (run_r) begin
      if (ms_r == target_ms) begin
        run_nxt = 1'b0;
        done_nxt = 1'b1;
      end else if (pre_r == 24'(MS_CYCLES - 1)) begin
        pre_nxt = 24'h000000;
        ms_nxt = ms_r + 8'h01;
      end else begin
        pre_nxt = pre_r + 24'h000001;
      end
    end
  end

  // Register the timer state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 24'h000000;
      ms_r <= 8'h00;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      ms_r <= ms_nxt;
      run_r <= run_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;

endmodule

// >>> tb/cfm_converter_model.sv
// Purpose: Behavioural power stage and power-good pin beside the fault monitor.
// Assumes: Enable and fast-off come from the monitor on the same clock.
// Notes: The pin has a pull-up, so it reads high unless some party pulls it low.
`timescale 1ns/100ps
module cfm_converter_model (
  input wire logic clk, // System clock.
  input wire logic conv_en, // Converter enable from the monitor.
  input wire logic fast_off, // Both switches off at once.
  input wire logic pg_oe, // Monitor pulls the pin.
  input wire logic pg_drive, // Value driven while pulling.
  input wire logic ext_low, // Outside circuit pulls the pin low.
  output logic ramp_done, // Output reached steady state.
  output logic falling, // Output ramps down.
  output logic off_done, // Ramp-down finished.
  output logic pg_pin // Resolved pin level.
);
  logic [3:0] up_r = 4'h0;
  logic [3:0] dn_r = 4'h0;
  // Count the ramp up while enabled, and a slower ramp down after a regular stop only.
  always @(posedge clk) begin
    if (conv_en) begin
      dn_r <= 4'h0;
      if (up_r != 4'h8) up_r <= up_r + 4'h1;
    end else begin
      up_r <= 4'h0;
      if (dn_r != 4'h0) dn_r <= (dn_r == 4'ha) ? 4'h0 : dn_r + 4'h1;
      else if (up_r != 4'h0 && !fast_off) dn_r <= 4'h1;
    end
  end
  // The fall starts a few cycles after the stop, so a command and the fall differ.
  assign ramp_done = up_r >= 4'h4;
  assign falling = dn_r >= 4'h4;
  assign off_done = dn_r == 4'ha;
  // Any party pulling low wins over the pull-up.
  assign pg_pin = (pg_oe ? pg_drive : 1'b1) & ~ext_low;
endmodule

// >>> tb/cfm_monitor_bench.sv
// Purpose: Self-checking bench for the converter fault monitor.
// Assumes: Ten cycles make one millisecond in this run.
// Notes: Inputs change on the falling clock edge; outputs are read there too.
`timescale 1ns/100ps
module cfm_monitor_bench import cfm_pkg::*; ;
  localparam int MSC = 10;
  localparam logic [7:0] PCT_TAB [12] = '{8'h25, 8'h2f, 8'h38, 8'h41, 8'h4b, 8'h54,
    8'h5d, 8'h67, 8'h70, 8'h79, 8'h83, 8'h8c};
  logic SYS_CLK = 1'b0;
  logic RSTN = 1'b0;
  cfm_meas_type meas = '{8'sh19, 16'h0000, 16'h03e8, 16'h0000, 8'h00};
  cfm_cfg_type cfg = '{1'b0, 1'b0, 7'h50, 8'h03, 1'b0, 1'b0, 1'b0};
  logic turn_on = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic ext_low = 1'b0;
  logic ramp_done, vout_falling, off_done, pg_pin, pg_out, pg_oe, conv_en, fast_off, lt_en;
  logic [7:0] rdata, cl_pct, v;
  logic [2:0] lr_sel;
  cfm_status_type status;
  int fail_count = 0;
  int checks_done = 0;

  // The clock toggles every half period of 100 ns.
  always #50 SYS_CLK = ~SYS_CLK;

  cfm_monitor #(.MS_CYCLES(MSC)) i_cfm_monitor (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .MEAS(meas),
    .CFG(cfg), .TURN_ON(turn_on), .RAMP_DONE(ramp_done), .VOUT_FALLING(vout_falling),
    .OFF_DONE(off_done), .REG_WR(reg_wr), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_RDATA(rdata), .PG_IN(pg_pin), .PG_OUT(pg_out), .PG_OE(pg_oe),
    .CONV_ENABLE(conv_en), .FAST_OFF(fast_off), .STATUS(status),
    .LOAD_REG_SELECT(lr_sel), .LIMIT_TEMP_COMP_EN(lt_en), .CURRENT_LIMIT_PCT(cl_pct));

  cfm_converter_model i_cfm_converter_model (.clk(SYS_CLK), .conv_en(conv_en),
    .fast_off(fast_off), .pg_oe(pg_oe), .pg_drive(pg_out), .ext_low(ext_low),
    .ramp_done(ramp_done), .falling(vout_falling), .off_done(off_done), .pg_pin(pg_pin));

  // Basic timing, comparison and bounded waiting.
  task automatic tick(input int n);
    repeat (n) @(negedge SYS_CLK);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic sig(input int sel);
    case (sel)
      0: return pg_oe;
      1: return conv_en;
      2: return vout_falling;
      default: return status.power_good_flag;
    endcase
  endfunction
  task automatic wait_sig(input int sel, input logic exp, input int maxc);
    int n;
    n = 0;
    while (sig(sel) !== exp && n < maxc) begin
      tick(1);
      n++;
    end
    chk(16'(n < maxc), 16'h0001);
  endtask

  // Register port: a one-cycle write strobe, and reads with the address held two edges.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    tick(2);
    d = rdata;
  endtask

  // Reset values, every limit code, field writes and an unmapped address.
  task automatic t_regs();
    rd_reg(8'h08, v);
    chk(v, 8'h1b);
    chk({cl_pct, lr_sel, lt_en}, {8'h8c, 3'h0, 1'b1});
    wr_reg(8'h08, {4'hc, v[3:0]});
    tick(2);
    chk({lr_sel, lt_en}, {3'h6, 1'b0});
    for (int c = 0; c < 16; c++) begin
      rd_reg(8'h08, v);
      wr_reg(8'h08, {v[7:4], 4'(c)});
      tick(2);
      chk(cl_pct, PCT_TAB[c > 11 ? 11 : c]);
      chk(lr_sel, 3'h6);
    end
    wr_reg(8'h08, 8'he5);
    tick(2);
    chk({lr_sel, cl_pct}, {3'h7, 8'h54});
    wr_reg(8'h09, 8'hff);
    rd_reg(8'h09, v);
    chk(v, 8'h00);
    rd_reg(8'h08, v);
    chk(v, 8'he5);
  endtask

  // Turn on with the output low during the ramp, then wait out the release delay.
  task automatic power_up();
    meas.vout_mv = 16'h0000;
    turn_on = 1'b1;
    tick(3);
    chk({status.undervoltage_flag, pg_oe}, 2'b11);
    meas.vout_mv = meas.vset_mv;
    tick(27);
    chk(pg_oe, 1'b1);
    wait_sig(0, 1'b0, 40);
    chk(status.power_good_flag, 1'b1);
  endtask

  // Warning rises above 120, holds at 117 and clears below it; the converter keeps running.
  task automatic t_temp();
    meas.temp_c = 8'sh78;
    tick(2);
    chk(status.temp_warning_flag, 1'b0);
    meas.temp_c = 8'sh79;
    tick(2);
    chk({status.temp_warning_flag, status.temp_warning_alias_flag}, 2'b11);
    chk({conv_en, pg_oe, fast_off}, 3'b100);
    meas.temp_c = 8'sh75;
    tick(2);
    chk(status.temp_warning_flag, 1'b1);
    meas.temp_c = 8'sh74;
    tick(2);
    chk({status.temp_warning_flag, status.temp_warning_alias_flag}, 2'b00);
  endtask

  // Window edges for both selections, and a setpoint change that moves the window.
  task automatic t_window();
    meas.vout_mv = 16'h0424;
    tick(3);
    chk({pg_oe, status.power_good_flag, conv_en}, 3'b101);
    cfg.pg_high_sel = 1'b1;
    wait_sig(0, 1'b0, 40);
    meas.vout_mv = 16'h03ac;
    cfg.pg_low_sel = 1'b1;
    tick(3);
    chk({pg_oe, status.power_good_flag}, 2'b10);
    cfg.pg_low_sel = 1'b0;
    wait_sig(0, 1'b0, 40);
    cfg.pg_low_sel = 1'b1;
    meas.vout_mv = 16'h03e8;
    tick(3);
    meas.vset_mv = 16'h044c;
    tick(3);
    chk(pg_oe, 1'b1);
    meas.vout_mv = 16'h044c;
    wait_sig(0, 1'b0, 40);
  endtask

  // An outside pull-low on the pin counts as a warning.
  task automatic t_ext();
    ext_low = 1'b1;
    tick(6);
    chk(status.power_good_flag, 1'b0);
    ext_low = 1'b0;
    wait_sig(3, 1'b1, 40);
    wait_sig(0, 1'b0, 40);
  endtask

  // Turn-off with the pin dropping at the command, then at the start of the fall.
  task automatic t_off();
    cfg.pg_off_mode = 1'b0;
    turn_on = 1'b0;
    tick(2);
    chk({vout_falling, pg_oe}, 2'b01);
    tick(15);
    cfg.pg_off_mode = 1'b1;
    power_up();
    turn_on = 1'b0;
    tick(2);
    chk(pg_oe, 1'b0);
    wait_sig(2, 1'b1, 10);
    wait_sig(0, 1'b1, 3);
    tick(15);
  endtask

  // Overcurrent at exactly the limit, blind below the pre-bias, then a restart after 130 ms.
  task automatic t_oc();
    rd_reg(8'h08, v);
    wr_reg(8'h08, {v[7:4], 4'h0});
    tick(2);
    power_up();
    meas.vprebias_mv = 16'h07d0;
    meas.iout_pct = 8'h25;
    tick(4);
    chk({fast_off, status.overcurrent_flag, conv_en}, 3'b011);
    meas.vprebias_mv = 16'h0000;
    tick(2);
    chk({fast_off, status.overcurrent_flag, conv_en}, 3'b100);
    meas.iout_pct = 8'h00;
    tick(1250);
    chk(conv_en, 1'b0);
    wait_sig(1, 1'b1, 100);
    chk({fast_off, status.overcurrent_flag}, 2'b01);
    wait_sig(0, 1'b0, 60);
  endtask

  // Undervoltage in steady state stops the converter by a regular ramp-down.
  task automatic t_uv();
    meas.vout_mv = 16'h01f4;
    tick(2);
    chk({status.undervoltage_flag, conv_en, fast_off}, 3'b000);
    wait_sig(2, 1'b1, 10);
    turn_on = 1'b0;
    tick(15);
  endtask

  // Summary and verdict.
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Main sequence after five cycles of reset.
  initial begin
    tick(5);
    chk({pg_oe, conv_en, fast_off, status}, {3'b100, 5'b00011});
    RSTN = 1'b1;
    t_regs();
    power_up();
    t_temp();
    t_window();
    t_ext();
    t_off();
    t_oc();
    t_uv();
    finish_test();
  end

  // A hang ends the run as a failure.
  initial begin
    #(20000 * 100);
    fail_count++;
    finish_test();
  end
endmodule
